// [include/ein_pkg.sv]
// shared constants, types and helpers for the ethernet error injector
package ein_pkg;

   // generator clock and insertion periods
   localparam int unsigned EIN_CLK_HZ = 250_000_000;
   localparam int unsigned EIN_SEC_PERIOD_S = 1;
   localparam int unsigned EIN_LONG_PERIOD_S = 10;
   localparam int unsigned EIN_CYC_PER_SEC = EIN_SEC_PERIOD_S * EIN_CLK_HZ;
   localparam int unsigned EIN_SECS_PER_LONG = EIN_LONG_PERIOD_S / EIN_SEC_PERIOD_S;

   // widths of counters and fields
   localparam int EIN_CYC_W = 28;
   localparam int EIN_SECN_W = 4;
   localparam int EIN_BLK_W = 24;
   localparam int EIN_PEND_W = 16;
   localparam int EIN_BURST_W = 8;
   localparam int EIN_ALARM_W = 4;

   // values after reset and corruption constants
   localparam logic [EIN_PEND_W-1:0] EIN_PEND_RST = 16'h0000;
   localparam logic [EIN_PEND_W-1:0] EIN_PEND_MAX = 16'hFFFF;
   localparam logic [EIN_ALARM_W-1:0] EIN_ALARM_RST = 4'h0;
   localparam logic [1:0] EIN_SYNC_BAD = 2'h0;
   localparam logic [63:0] EIN_FLIP_MASK = 64'h0000_0000_0000_0001;
   localparam logic [63:0] EIN_PRE_MASK = 64'h0000_0000_0000_0100;
   localparam logic [63:0] EIN_MF_MASK = 64'h0000_0000_0000_2000;

   // insertion schedules
   typedef enum logic [3:0] {
      EIN_SCH_OFF = 4'h0,
      EIN_SCH_MANUAL = 4'h1,
      EIN_SCH_SEC = 4'h2,
      EIN_SCH_TEN_SEC = 4'h3,
      EIN_SCH_R2 = 4'h4,
      EIN_SCH_R3 = 4'h5,
      EIN_SCH_R4 = 4'h6,
      EIN_SCH_R5 = 4'h7,
      EIN_SCH_R6 = 4'h8,
      EIN_SCH_R7 = 4'h9
   } ein_sched_t;

   // insertion destinations
   typedef enum logic [3:0] {
      EIN_DST_FCS = 4'h0,
      EIN_DST_PREAMBLE = 4'h1,
      EIN_DST_IP_CSUM = 4'h2,
      EIN_DST_IP_FRAG = 4'h3,
      EIN_DST_L4_CSUM = 4'h4,
      EIN_DST_PATTERN = 4'h5,
      EIN_DST_SEQ = 4'h6,
      EIN_DST_SYMBOL = 4'h7,
      EIN_DST_FEC = 4'h8
   } ein_dest_t;

   // injector state
   typedef enum logic [2:0] {
      EIN_ST_OFF = 3'b001,
      EIN_ST_IDLE = 3'b010,
      EIN_ST_BURST = 3'b100
   } ein_state_t;

   // one beat of outgoing traffic
   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic [1:0] sync;
      logic [63:0] data;
      logic [7:0] ctrl;
      logic tx_er;
   } ein_beat_t;

   // generator markers telling which field the beat carries
   typedef struct packed {
      logic preamble;
      logic fcs;
      logic ip_csum;
      logic ip_frag;
      logic l4_csum;
      logic pattern;
      logic seq;
      logic blk;
   } ein_mark_t;

   // true for the ratio schedules
   function automatic logic ein_is_ratio(input ein_sched_t s);
      return (s >= EIN_SCH_R2) && (s <= EIN_SCH_R7);
   endfunction : ein_is_ratio

   // blocks per burst for each ratio schedule
   function automatic logic [EIN_BLK_W-1:0] ein_decade(input ein_sched_t s);
      case (s)
         EIN_SCH_R2: return 24'h000064;
         EIN_SCH_R3: return 24'h0003E8;
         EIN_SCH_R4: return 24'h002710;
         EIN_SCH_R5: return 24'h0186A0;
         EIN_SCH_R6: return 24'h0F4240;
         EIN_SCH_R7: return 24'h989680;
         default: return 24'h000000;
      endcase
   endfunction : ein_decade

endpackage : ein_pkg

// [rtl/ein_error_injector.sv]
// ethernet error and alarm injector on the generator transmit stream
//
// Function
// RULE_01 - selected alarm applied continuously, schedule independent
// RULE_02 - schedule off passes traffic unchanged
// RULE_03 - manual trigger inserts exactly burst count errors
// RULE_04 - one burst every second
// RULE_05 - one burst every ten seconds
// RULE_06 - ratio schedules: one burst per decade blocks
// RULE_07 - trigger ignored in ratio, shows status only
// RULE_08 - fcs destination sends wrong frame check
// RULE_09 - preamble destination sends altered preamble pattern
// RULE_10 - ip checksum destination sends wrong header checksum
// RULE_11 - fragment destination sends fragmented ipv4 packets
// RULE_12 - layer-4 destination sends wrong tcp/udp checksum
// RULE_13 - pattern destination flips payload test pattern bit
// RULE_14 - sequence destination corrupts frame sequence number
// RULE_15 - symbol: bad 64/66b header, else tx error
// RULE_16 - fec symbol error only when fec enabled
// RULE_17 - trigger edge-detected; schedule change restarts counters
module ein_error_injector #(
   parameter int unsigned CYC_PER_SEC = ein_pkg::EIN_CYC_PER_SEC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // configuration
   input wire ein_pkg::ein_sched_t sched,
   input wire ein_pkg::ein_dest_t dest,
   input wire logic [ein_pkg::EIN_BURST_W-1:0] burst_len,
   input wire logic speed_10g,
   input wire logic fec_en,
   input wire logic alarm_en,
   input wire logic [ein_pkg::EIN_ALARM_W-1:0] alarm_sel,
   // manual insert trigger
   input wire logic insert_trig,
   // traffic from the generator
   input wire ein_pkg::ein_beat_t beat_in,
   input wire ein_pkg::ein_mark_t mark_in,
   // traffic toward the device under test
   output ein_pkg::ein_beat_t beat_out,
   output logic fec_sym_err,
   // alarm and status
   output logic [ein_pkg::EIN_ALARM_W-1:0] alarm_out,
   output logic insert_busy,
   output logic ratio_active,
   output logic [ein_pkg::EIN_PEND_W-1:0] pending
);
   import ein_pkg::*;

   // history, state and pending count
   ein_sched_t sched_q;
   ein_state_t state_q;
   ein_state_t state_d;
   logic trig_q;
   logic [EIN_PEND_W-1:0] pend_q;
   logic [EIN_PEND_W-1:0] pend_d;
   // registered traffic and status
   ein_beat_t beat_q;
   ein_beat_t beat_d;
   logic fec_q;
   logic [EIN_ALARM_W-1:0] alarm_q;
   logic busy_q;
   logic ratio_q;
   // internal strobes
   logic restart;
   logic sec_tick;
   logic ten_tick;
   logic ratio_fire;
   logic trig_edge;
   logic fire;
   logic on_field;
   logic hit;
   logic sched_off;
   logic blk_beat;

   // saturating add of a burst to the pending count
   function automatic logic [EIN_PEND_W-1:0] add_sat(input logic [EIN_PEND_W-1:0] a,
                                                     input logic [EIN_BURST_W-1:0] b);
      logic [EIN_PEND_W:0] s;
      s = {1'b0, a} + {{(EIN_PEND_W + 1 - EIN_BURST_W){1'b0}}, b};
      return s[EIN_PEND_W] ? EIN_PEND_MAX : s[EIN_PEND_W-1:0];
   endfunction : add_sat

   // any change of schedule restarts every period and block counter
   assign restart = (sched != sched_q); // RULE_17
   assign sched_off = (sched == EIN_SCH_OFF);

   // second and ten-second pulses, restarted with the schedule
   ein_period_tick #(
      .CYC_PER_SEC(CYC_PER_SEC)
   ) u_period (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(restart),
      .sec_tick(sec_tick),
      .ten_tick(ten_tick)
   );

   // beats that count toward the ratio decades
   assign blk_beat = beat_in.valid && mark_in.blk;

   ein_ratio_tick u_ratio (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(restart),
      .sched(sched),
      .blk(blk_beat),
      .fire(ratio_fire)
   );

   // rising edge only, so a held trigger yields one burst
   assign trig_edge = insert_trig && !trig_q; // RULE_17

   // burst launch per schedule; trigger counts only in manual
   always_comb begin
      fire = 1'b0;
      case (sched)
         EIN_SCH_MANUAL: fire = trig_edge; // RULE_03
         EIN_SCH_SEC: fire = sec_tick; // RULE_04
         EIN_SCH_TEN_SEC: fire = ten_tick; // RULE_05
         default: fire = ein_is_ratio(sched) && ratio_fire; // RULE_06 RULE_07
      endcase
   end

   // does the current beat carry the field of the chosen destination
   always_comb begin
      on_field = 1'b0;
      case (dest)
         EIN_DST_FCS: on_field = mark_in.fcs;
         EIN_DST_PREAMBLE: on_field = mark_in.preamble;
         EIN_DST_IP_CSUM: on_field = mark_in.ip_csum;
         EIN_DST_IP_FRAG: on_field = mark_in.ip_frag;
         EIN_DST_L4_CSUM: on_field = mark_in.l4_csum;
         EIN_DST_PATTERN: on_field = mark_in.pattern;
         EIN_DST_SEQ: on_field = mark_in.seq;
         EIN_DST_SYMBOL: on_field = mark_in.blk;
         EIN_DST_FEC: on_field = mark_in.blk && fec_en; // RULE_16
         default: on_field = 1'b0;
      endcase
   end

   // one error is spent on each matching beat while the burst runs
   assign hit = (state_q == EIN_ST_BURST) && beat_in.valid && on_field && !restart;

   // state: off, waiting for a burst, or spending a burst
   always_comb begin
      state_d = state_q;
      case (state_q)
         EIN_ST_OFF: begin
            if (!sched_off) begin
               state_d = EIN_ST_IDLE;
            end
         end
         EIN_ST_IDLE: begin
            if (sched_off) begin
               state_d = EIN_ST_OFF;
            end else if (pend_d != EIN_PEND_RST) begin
               state_d = EIN_ST_BURST;
            end
         end
         EIN_ST_BURST: begin
            if (sched_off) begin
               state_d = EIN_ST_OFF;
            end else if (pend_d == EIN_PEND_RST) begin
               state_d = EIN_ST_IDLE;
            end
         end
         default: state_d = EIN_ST_OFF;
      endcase
   end

   // pending errors: bursts add, matching beats take one each
   always_comb begin
      pend_d = pend_q;
      if (sched_off || restart) begin
         pend_d = EIN_PEND_RST; // RULE_02 RULE_17
      end else begin
         if (hit) begin
            pend_d = pend_q - 1'b1; // RULE_03
         end
         if (fire && burst_len != '0) begin
            pend_d = add_sat(pend_d, burst_len);
         end
      end
   end

   // corrupt the beat in place; nothing is touched without a hit
   always_comb begin
      beat_d = beat_in; // RULE_02
      beat_d.tx_er = beat_in.tx_er;
      if (hit) begin
         case (dest)
            EIN_DST_FCS: beat_d.data = beat_in.data ^ EIN_FLIP_MASK; // RULE_08
            EIN_DST_PREAMBLE: beat_d.data = beat_in.data ^ EIN_PRE_MASK; // RULE_09
            EIN_DST_IP_CSUM: beat_d.data = beat_in.data ^ EIN_FLIP_MASK; // RULE_10
            EIN_DST_IP_FRAG: beat_d.data = beat_in.data | EIN_MF_MASK; // RULE_11
            EIN_DST_L4_CSUM: beat_d.data = beat_in.data ^ EIN_FLIP_MASK; // RULE_12
            EIN_DST_PATTERN: beat_d.data = beat_in.data ^ EIN_FLIP_MASK; // RULE_13
            EIN_DST_SEQ: beat_d.data = beat_in.data ^ EIN_FLIP_MASK; // RULE_14
            EIN_DST_SYMBOL: begin
               if (speed_10g) begin
                  beat_d.sync = EIN_SYNC_BAD; // RULE_15
               end else begin
                  beat_d.tx_er = 1'b1; // RULE_15
               end
            end
            default: beat_d = beat_in;
         endcase
      end
   end

   // schedule history, compared against the live schedule to spot a change
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sched_q <= EIN_SCH_OFF;
      end else begin
         sched_q <= sched;
      end
   end

   // trigger history; resets low like an idle trigger, so no false edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= insert_trig;
      end
   end

   // injector state
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= EIN_ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // pending error count
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_q <= EIN_PEND_RST;
      end else begin
         pend_q <= pend_d;
      end
   end

   // registered traffic out, one cycle of latency
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         beat_q <= '0;
      end else begin
         beat_q <= beat_d;
      end
   end

   // fec symbol error pulse, aligned with the hit block on beat_out
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fec_q <= 1'b0;
      end else begin
         fec_q <= hit && (dest == EIN_DST_FEC); // RULE_16
      end
   end

   // alarm follows its selection, whatever the schedule does
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         alarm_q <= EIN_ALARM_RST;
      end else begin
         alarm_q <= alarm_en ? alarm_sel : EIN_ALARM_RST; // RULE_01
      end
   end

   // ratio flag: in ratio mode the trigger only reports activity
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ratio_q <= 1'b0;
      end else begin
         ratio_q <= ein_is_ratio(sched); // RULE_07
      end
   end

   // busy while a burst runs or a ratio schedule keeps inserting
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d == EIN_ST_BURST) || ein_is_ratio(sched);
      end
   end

   // every output straight from its flop
   assign beat_out = beat_q;
   assign fec_sym_err = fec_q;
   assign alarm_out = alarm_q;
   assign insert_busy = busy_q;
   assign ratio_active = ratio_q;
   assign pending = pend_q;

endmodule : ein_error_injector

// [rtl/ein_period_tick.sv]
// one-second and ten-second enable pulses for periodic bursts
module ein_period_tick #(
   parameter int unsigned CYC_PER_SEC = ein_pkg::EIN_CYC_PER_SEC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic clr,
   // pulses
   output logic sec_tick,
   output logic ten_tick
);
   import ein_pkg::*;

   localparam logic [EIN_CYC_W-1:0] CYC_LAST = EIN_CYC_W'(CYC_PER_SEC - 1);
   localparam logic [EIN_SECN_W-1:0] SEC_LAST = EIN_SECN_W'(EIN_SECS_PER_LONG - 1);

   logic [EIN_CYC_W-1:0] cyc_q;
   logic [EIN_SECN_W-1:0] secn_q;
   logic wrap;

   assign wrap = (cyc_q == CYC_LAST);
   assign sec_tick = wrap && !clr;
   assign ten_tick = wrap && !clr && (secn_q == SEC_LAST);

   // cycle counter, restarted on a new schedule
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cyc_q <= '0;
      end else if (clr || wrap) begin
         cyc_q <= '0;
      end else begin
         cyc_q <= cyc_q + 1'b1;
      end
   end

   // seconds within the ten-second period
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         secn_q <= '0;
      end else if (clr) begin
         secn_q <= '0;
      end else if (wrap) begin
         secn_q <= (secn_q == SEC_LAST) ? '0 : secn_q + 1'b1;
      end
   end

endmodule : ein_period_tick

// [rtl/ein_ratio_tick.sv]
// block counter that fires once per decade of blocks in ratio schedules
module ein_ratio_tick (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic clr,
   input wire ein_pkg::ein_sched_t sched,
   input wire logic blk,
   // pulse
   output logic fire
);
   import ein_pkg::*;

   logic [EIN_BLK_W-1:0] cnt_q;
   logic [EIN_BLK_W-1:0] last;
   logic active;

   assign active = ein_is_ratio(sched);
   assign last = ein_decade(sched) - 1'b1;
   assign fire = active && !clr && blk && (cnt_q == last);

   // counts blocks; the burst fires on the last block of each group
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (clr || !active) begin
         cnt_q <= '0;
      end else if (blk) begin
         cnt_q <= (cnt_q == last) ? '0 : cnt_q + 1'b1;
      end
   end

endmodule : ein_ratio_tick

// [tb/ein_error_injector_monitor.sv]
// port-level assertion checker for the ethernet error injector
module ein_error_injector_monitor #(
   parameter int unsigned CYC_PER_SEC = ein_pkg::EIN_CYC_PER_SEC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // configuration and trigger
   input wire ein_pkg::ein_sched_t sched,
   input wire ein_pkg::ein_dest_t dest,
   input wire logic [ein_pkg::EIN_BURST_W-1:0] burst_len,
   input wire logic speed_10g,
   input wire logic fec_en,
   input wire logic alarm_en,
   input wire logic [ein_pkg::EIN_ALARM_W-1:0] alarm_sel,
   input wire logic insert_trig,
   // traffic
   input wire ein_pkg::ein_beat_t beat_in,
   input wire ein_pkg::ein_mark_t mark_in,
   input wire ein_pkg::ein_beat_t beat_out,
   input wire logic fec_sym_err,
   // status
   input wire logic [ein_pkg::EIN_ALARM_W-1:0] alarm_out,
   input wire logic insert_busy,
   input wire logic ratio_active,
   input wire logic [ein_pkg::EIN_PEND_W-1:0] pending
);
   timeunit 1ns;
   timeprecision 1ps;
   import ein_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // past() guards keep the first edge after reset out of the relations
   property p_alarm;
      !$past(rst) |-> alarm_out == ($past(alarm_en) ? $past(alarm_sel) : EIN_ALARM_RST);
   endproperty
   property p_off_pass;
      !$past(rst) && $past(sched) == EIN_SCH_OFF |-> beat_out == $past(beat_in);
   endproperty
   property p_off_clear;
      sched == EIN_SCH_OFF |=> pending == EIN_PEND_RST && !insert_busy;
   endproperty
   property p_trig_burst;
      !$past(rst) && $rose(insert_trig) && sched == EIN_SCH_MANUAL && $stable(sched)
         && pending == EIN_PEND_RST |=> pending == 16'($past(burst_len));
   endproperty
   property p_trig_held;
      insert_trig && $past(insert_trig) && sched == EIN_SCH_MANUAL |=> pending <= $past(pending);
   endproperty
   property p_ratio_flag;
      !$past(rst) |-> ratio_active == ($past(sched) >= EIN_SCH_R2 && $past(sched) <= EIN_SCH_R7);
   endproperty
   property p_ratio_busy;
      ratio_active |-> insert_busy;
   endproperty
   property p_fcs_flip;
      !$past(rst) && $past(dest) == EIN_DST_FCS && beat_out.data != $past(beat_in.data)
         |-> beat_out.data == ($past(beat_in.data) ^ EIN_FLIP_MASK);
   endproperty
   property p_fec_gate;
      fec_sym_err |-> $past(fec_en) && $past(dest) == EIN_DST_FEC;
   endproperty
   property p_sym_kind;
      !$past(rst) && (beat_out.sync != $past(beat_in.sync)
         || beat_out.tx_er != $past(beat_in.tx_er))
         |-> $past(dest) == EIN_DST_SYMBOL
         && ($past(speed_10g) ? beat_out.sync == EIN_SYNC_BAD : beat_out.tx_er);
   endproperty
   property p_spend;
      !$past(rst) && beat_out != $past(beat_in) |-> $past(pending) != EIN_PEND_RST;
   endproperty

   a_alarm: assert property (p_alarm) else $error("alarm output wrong");
   a_off_pass: assert property (p_off_pass) else $error("traffic altered when off");
   a_off_clear: assert property (p_off_clear) else $error("pending kept when off");
   a_trig_burst: assert property (p_trig_burst) else $error("burst count wrong");
   a_trig_held: assert property (p_trig_held) else $error("held trigger re-fired");
   a_ratio_flag: assert property (p_ratio_flag) else $error("ratio flag wrong");
   a_ratio_busy: assert property (p_ratio_busy) else $error("busy low in ratio");
   a_fcs_flip: assert property (p_fcs_flip) else $error("frame check damage wrong");
   a_fec_gate: assert property (p_fec_gate) else $error("fec error while disabled");
   a_sym_kind: assert property (p_sym_kind) else $error("symbol damage of wrong kind");
   a_spend: assert property (p_spend) else $error("damage with no pending error");

   // main scenarios reached
   c_ratio: cover property (ratio_active);
   c_fec: cover property (fec_sym_err);
   c_trig: cover property ($rose(insert_trig) && sched == EIN_SCH_MANUAL);
endmodule : ein_error_injector_monitor

bind ein_error_injector ein_error_injector_monitor #(.CYC_PER_SEC(CYC_PER_SEC)) mon_u (
   .ref_clk, .rst, .sched, .dest, .burst_len, .speed_10g, .fec_en, .alarm_en, .alarm_sel,
   .insert_trig, .beat_in, .mark_in, .beat_out, .fec_sym_err, .alarm_out, .insert_busy,
   .ratio_active, .pending
);

// [tb/ein_peer_model.sv]
// far-side receiver model counting damaged blocks
module ein_peer_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // traffic from the injector
   input wire ein_pkg::ein_beat_t beat_rx,
   input wire logic fec_err_rx,
   // damaged block count
   output int bad_cnt_q
);
   timeunit 1ns;
   timeprecision 1ps;
   import ein_pkg::*;
   // bad sync header, tx error or fec symbol hit all count as one damaged block
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bad_cnt_q <= 0;
      end else if (fec_err_rx
                   || (beat_rx.valid && (beat_rx.tx_er || beat_rx.sync == EIN_SYNC_BAD))) begin
         bad_cnt_q <= bad_cnt_q + 1;
      end
   end
endmodule : ein_peer_model

// [tb/testbench.sv]
// self-checking bench for the ethernet error injector
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ein_pkg::*;
   // short second keeps periodic runs brief
   localparam int unsigned CPS = 20;
   localparam logic [63:0] PAY = 64'hA5A5_0000_0000_0000;
   typedef struct packed {
      ein_dest_t dest;
      logic spd;
      logic fec;
      logic [7:0] mark;
      logic [15:0] mask;
   } ein_row_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   ein_sched_t sched = EIN_SCH_OFF;
   ein_dest_t dest = EIN_DST_FCS;
   logic [7:0] burst_len = 8'h01;
   logic speed_10g = 1'b1;
   logic fec_en = 1'b0;
   logic alarm_en = 1'b1;
   logic [3:0] alarm_sel = 4'h9;
   logic insert_trig = 1'b0;
   ein_beat_t beat_in = '{1'b1, 1'b0, 1'b0, 2'h1, PAY, 8'h00, 1'b0};
   ein_mark_t mark_in = '0;
   ein_beat_t beat_out;
   logic fec_sym_err;
   logic insert_busy;
   logic ratio_active;
   logic [3:0] alarm_out;
   logic [15:0] pending;
   int bad_cnt_q;
   int failures = 0;
   int checks = 0;
   // destination, speed, fec enable, marker, expected data damage
   ein_row_t rows [11] = '{
      '{EIN_DST_FCS, 1'b1, 1'b0, 8'h40, 16'h0001}, '{EIN_DST_PREAMBLE, 1'b1, 1'b0, 8'h80, 16'h0100},
      '{EIN_DST_IP_CSUM, 1'b1, 1'b0, 8'h20, 16'h0001}, '{EIN_DST_IP_FRAG, 1'b1, 1'b0, 8'h10, 16'h2000},
      '{EIN_DST_L4_CSUM, 1'b1, 1'b0, 8'h08, 16'h0001}, '{EIN_DST_PATTERN, 1'b1, 1'b0, 8'h04, 16'h0001},
      '{EIN_DST_SEQ, 1'b1, 1'b0, 8'h02, 16'h0001}, '{EIN_DST_SYMBOL, 1'b1, 1'b0, 8'h01, 16'h0000},
      '{EIN_DST_SYMBOL, 1'b0, 1'b0, 8'h01, 16'h0000}, '{EIN_DST_FEC, 1'b1, 1'b1, 8'h01, 16'h0000},
      '{EIN_DST_FEC, 1'b1, 1'b0, 8'h01, 16'h0000}};

   ein_error_injector #(.CYC_PER_SEC(CPS)) dut_u (
      .ref_clk, .rst, .sched, .dest, .burst_len, .speed_10g, .fec_en, .alarm_en, .alarm_sel,
      .insert_trig, .beat_in, .mark_in, .beat_out, .fec_sym_err, .alarm_out, .insert_busy,
      .ratio_active, .pending
   );
   ein_peer_model peer_u (.ref_clk, .rst, .beat_rx(beat_out), .fec_err_rx(fec_sym_err),
      .bad_cnt_q);

   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   // inputs move 1 ns after the rising edge
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   // restart, then time two bursts; the toggling trigger must change nothing
   task automatic intv(input ein_sched_t s, input int exp);
      int c;
      logic [15:0] p;
      sched = EIN_SCH_OFF;
      tick();
      sched = s;
      c = 0;
      while (pending === 16'h0000 && c < 4 * exp) begin
         insert_trig = ~insert_trig;
         tick();
         c++;
      end
      chk(c, exp + 1);
      p = pending;
      c = 0;
      while (pending === p && c < 4 * exp) begin
         insert_trig = ~insert_trig;
         tick();
         c++;
      end
      chk(c, exp);
      chk(pending, p + 16'(burst_len));
   endtask : intv

   initial begin
      ein_row_t r;
      int c;
      tick(4);
      chk({beat_out, pending}, '0);
      rst = 1'b0;
      tick();
      chk(alarm_out, 4'h9);
      // one manual single-error burst per destination row
      foreach (rows[i]) begin
         r = rows[i];
         sched = EIN_SCH_OFF;
         dest = r.dest;
         speed_10g = r.spd;
         fec_en = r.fec;
         mark_in = ein_mark_t'(r.mark);
         insert_trig = 1'b1;
         tick(2);
         chk({beat_out, pending}, {beat_in, 16'h0000});
         insert_trig = 1'b0;
         mark_in = '0;
         sched = EIN_SCH_MANUAL;
         tick(2);
         insert_trig = 1'b1;
         tick();
         insert_trig = 1'b0;
         tick(3);
         mark_in = ein_mark_t'(r.mark);
         tick();
         mark_in = '0;
         chk(beat_out.data[15:0], PAY[15:0] ^ r.mask);
         chk(beat_out.data, PAY ^ 64'(r.mask));
         chk(beat_out.sync, (r.dest == EIN_DST_SYMBOL && r.spd) ? EIN_SYNC_BAD : 2'h1);
         chk(beat_out.tx_er, r.dest == EIN_DST_SYMBOL && !r.spd);
         chk(fec_sym_err, r.dest == EIN_DST_FEC && r.fec);
         chk(alarm_out, 4'h9);
      end
      chk(bad_cnt_q, 3);
      // held trigger gives one burst of three over back-to-back beats
      sched = EIN_SCH_OFF;
      tick();
      sched = EIN_SCH_MANUAL;
      dest = EIN_DST_PATTERN;
      burst_len = 8'h03;
      tick(2);
      insert_trig = 1'b1;
      tick(6);
      chk({insert_busy, pending}, 17'h1_0003);
      mark_in = ein_mark_t'(8'h04);
      c = 0;
      repeat (5) begin
         tick();
         if (beat_out.data !== PAY) c++;
      end
      chk(c, 3);
      chk({insert_busy, pending}, 17'h0_0000);
      insert_trig = 1'b0;
      // block markers feed the ratio counter; pattern destination takes no hits
      mark_in = ein_mark_t'(8'h01);
      burst_len = 8'h02;
      intv(EIN_SCH_SEC, CPS);
      intv(EIN_SCH_TEN_SEC, 10 * CPS);
      intv(EIN_SCH_R2, 100);
      chk({ratio_active, insert_busy}, 2'b11);
      intv(EIN_SCH_R3, 1000);
      intv(EIN_SCH_R4, 10000);
      // the longest decades only get their decode checked; a full run is too long
      for (int k = 7; k <= 9; k++) begin
         sched = ein_sched_t'(k);
         tick(2);
         chk({ratio_active, insert_busy, pending}, 18'h3_0000);
      end
      alarm_en = 1'b0;
      tick(2);
      chk(alarm_out, 4'h0);
      end_of_test();
   end

   // runaway guard, about twice the expected run of some 23000 cycles
   initial begin
      #200000;
      failures++;
      end_of_test();
   end
endmodule : testbench
